// ---- sim/tb_timer_capture_compare_routing.sv ----
/*
 * Self-checking bench of the timer block: apb tasks, clock source pulses,
 * compare, capture and trigger routing tests.
 * Assumes tcr_top, tcr_monitor and tcr_trig_sink are compiled before it.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_timer_capture_compare_routing;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   logic rerr;
   logic [5:0] src; // ext, aux, sub, alt, comparator, capture pin a
   logic [2:0][2:0] timer_pin_out, timer_pin_oe_n;
   logic [3:0] adc_trigger_select;
   logic [1:0] powerup_trigger_select, sequencer_trigger_select;
   logic adc_trigger, ultrasonic_powerup_trigger, acq_sequencer_trigger;
   logic [7:0] adc_hits, pwr_hits, seq_hits;
   int fail_count = 0;
   int n_tests = 0;
   int cycles = 0;

   tcr_top tcr_top_inst (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .irq, .ext_timer_clock_in({3{src[0]}}),
      .alt_timer_clock_in({3{src[3]}}), .aux_clock(src[1]), .sub_main_clock(src[2]),
      .comparator_output(src[4]), .cap_a_pin_in({9{src[5]}}), .cap_b_pin_in(9'h000),
      .timer_pin_out, .timer_pin_oe_n, .adc_trigger_select, .powerup_trigger_select,
      .sequencer_trigger_select, .adc_trigger, .ultrasonic_powerup_trigger,
      .acq_sequencer_trigger);

   tcr_trig_sink sink_inst (.pclk, .presetn, .adc_trigger, .ultrasonic_powerup_trigger,
      .acq_sequencer_trigger, .adc_hits, .pwr_hits, .seq_hits);

   // 50 mhz clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // hang guard
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one apb transfer, held until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) fail_count++;
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat, e);
   endtask

   // n rising edges on one clock or capture source
   task automatic pulse(input int b, input int n);
      repeat (n) begin
         @(posedge pclk);
         src[b] <= 1'b1;
         @(posedge pclk);
         src[b] <= 1'b0;
      end
      repeat (3) @(posedge pclk);
   endtask

   // main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      src = 6'h00;
      adc_trigger_select = 4'h4;
      powerup_trigger_select = 2'h2;
      sequencer_trigger_select = 2'h2;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'h004, 32'h0);
      chk(32'(timer_pin_oe_n), 32'h1ff);
      chk(32'(irq), 32'h0);
      $display("test reset done");
      for (int s = 0; s < 4; s++) begin
         wr(12'h000, 32'(4 | s));
         wr(12'h004, 32'h0);
         pulse(s, 3);
         rd(12'h004, 32'h3);
      end
      $display("test clock select done");
      wr(12'h104, 32'h1);
      wr(12'h100, 32'hfff);
      wr(12'h004, 32'hffff);
      pulse(3, 1);
      rd(12'h004, 32'h0);
      rd(12'h100, 32'h00f);
      chk(32'(irq), 32'h1);
      wr(12'h100, 32'hfff);
      @(posedge pclk);
      chk(32'(irq), 32'h0);
      $display("test wrap done");
      for (int t = 0; t < 2; t++) begin
         wr(12'(t * 64 + 16), 32'h50);
         wr(12'(t * 64 + 20), 32'(5 + t));
         wr(12'(t * 64 + 24), 32'h50);
         wr(12'(t * 64 + 28), 32'(5 + t));
         wr(12'(t * 64), 32'h6);
         wr(12'(t * 64 + 4), 32'h0);
      end
      pulse(2, 5);
      chk(32'(adc_trigger), 32'h0);
      chk(32'(ultrasonic_powerup_trigger), 32'h1);
      chk(32'(acq_sequencer_trigger), 32'h0);
      chk(32'(timer_pin_out[0][1]), 32'h1);
      chk(32'(timer_pin_oe_n[0][1]), 32'h0);
      pulse(2, 1);
      chk(32'(adc_trigger), 32'h1);
      chk(32'(acq_sequencer_trigger), 32'h1);
      rd(12'h100, 32'h0cc);
      adc_trigger_select <= 4'h0;
      repeat (3) @(posedge pclk);
      chk(32'(adc_trigger), 32'h0);
      adc_trigger_select <= 4'h1;
      repeat (3) @(posedge pclk);
      chk(32'(adc_hits), 32'h2);
      chk(32'({pwr_hits, seq_hits}), 32'h0101);
      $display("test compare routing done");
      wr(12'h000, 32'h2);
      wr(12'h004, 32'h1234);
      wr(12'h010, 32'h3);
      pulse(4, 1);
      rd(12'h014, 32'h1234);
      wr(12'h018, 32'h3);
      wr(12'h004, 32'h0abc);
      pulse(1, 1);
      rd(12'h01c, 32'h0abc);
      rd(12'h014, 32'h1234);
      wr(12'h008, 32'h5);
      wr(12'h008, 32'h7);
      rd(12'h00c, 32'h0abc);
      $display("test capture done");
      rd(12'h098, 32'h0);
      chk(32'(rerr), 32'h1);
      rd(12'h090, 32'h0);
      chk(32'(rerr), 32'h0);
      rd(12'h200, 32'h0);
      chk(32'(rerr), 32'h1);
      wr(12'h080, 32'h4);
      wr(12'h084, 32'h0);
      pulse(0, 2);
      rd(12'h084, 32'h2);
      $display("test timer 4 and map done");
      // timer 4 unit 0: level bit, then inverted pwm and pwm around compare value 3
      wr(12'h08c, 32'h3);
      wr(12'h088, 32'h60);
      repeat (2) @(posedge pclk);
      chk(32'({timer_pin_out[2][0], timer_pin_oe_n[2][0]}), 32'h2);
      for (int m = 0; m < 2; m++) begin
         wr(12'h088, m ? 32'h48 : 32'h58);
         wr(12'h084, 32'hffff);
         pulse(0, 1);
         chk(32'(timer_pin_out[2][0]), 32'(m));
         pulse(0, 3);
         chk(32'(timer_pin_out[2][0]), 32'(1 - m));
      end
      // timer 4 unit 1 captures the stopped count on a rise of pin a
      wr(12'h090, 32'h1);
      pulse(5, 1);
      rd(12'h094, 32'h3);
      $display("test pwm and pin capture done");
      end_of_test();
   end
endmodule

`default_nettype wire

// ---- sim/tcr_monitor.sv ----
/*
 * Checker of pin and trigger routing of the timer capture/compare block.
 * Assumes binding into tcr_top, one pclk domain, reset presetn.
 */
`timescale 1ns/100ps
`default_nettype none

module tcr_monitor #(
   parameter bit HAS_ADC = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [2:0] ext_timer_clock_in,
   input wire logic [2:0] alt_timer_clock_in,
   input wire logic aux_clock,
   input wire logic sub_main_clock,
   input wire logic [2:0][2:0] timer_pin_out,
   input wire logic [2:0][2:0] timer_pin_oe_n,
   input wire logic [3:0] adc_trigger_select,
   input wire logic [1:0] powerup_trigger_select,
   input wire logic [1:0] sequencer_trigger_select,
   input wire logic adc_trigger,
   input wire logic ultrasonic_powerup_trigger,
   input wire logic acq_sequencer_trigger
);
   logic [7:0] src_d1;
   logic [7:0] src_d2;
   logic wr_d1;
   logic wr_acc;
   logic t0_adc;
   logic t1_adc;

   // write access and the two adc trigger causes
   assign wr_acc = psel & penable & pwrite;
   assign t0_adc = (adc_trigger_select == 4'h1) & timer_pin_out[0][1];
   assign t1_adc = (adc_trigger_select == 4'h4) & timer_pin_out[1][1];

   // history of clock sources and writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_d1 <= 8'h00;
         src_d2 <= 8'h00;
         wr_d1 <= 1'b0;
      end else begin
         src_d1 <= {ext_timer_clock_in, alt_timer_clock_in, aux_clock, sub_main_clock};
         src_d2 <= src_d1;
         wr_d1 <= wr_acc;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_adc_t0_route: assert property (t0_adc |=> adc_trigger)
      else $error("adc trigger missed timer 0 unit 1");
   a_adc_t1_route: assert property (t1_adc |=> adc_trigger)
      else $error("adc trigger missed timer 1 unit 1");
   a_adc_no_cause: assert property (!(t0_adc | t1_adc) |=> !adc_trigger)
      else $error("adc trigger without a selected source");
   a_adc_variant: assert property (adc_trigger |-> HAS_ADC)
      else $error("adc trigger on a variant without adc");
   a_powerup_route: assert property (1'b1 |=> ultrasonic_powerup_trigger ==
      $past((powerup_trigger_select == 2'h2) & timer_pin_out[0][2]))
      else $error("power-up trigger does not follow timer 0 unit 2");
   a_seq_route: assert property (1'b1 |=> acq_sequencer_trigger ==
      $past((sequencer_trigger_select == 2'h2) & timer_pin_out[1][2]))
      else $error("sequencer trigger does not follow timer 1 unit 2");
   a_absent_unit: assert property (timer_pin_oe_n[2][2] && !timer_pin_out[2][2])
      else $error("absent unit of timer 4 drives its pin");
   a_out_has_cause: assert property ($changed(timer_pin_out) |->
      $past(wr_acc) || $past(wr_d1) || (|(src_d1 & ~src_d2)))
      else $error("unit output moved without tick or write");
   a_pin_en_write: assert property ($changed(timer_pin_oe_n) |-> $past(wr_acc))
      else $error("pin enable moved without a write");

   c_adc_rise: cover property ($rose(adc_trigger));
   c_powerup_rise: cover property ($rose(ultrasonic_powerup_trigger));
   c_seq_rise: cover property ($rose(acq_sequencer_trigger));
endmodule

bind tcr_top tcr_monitor #(.HAS_ADC(HAS_ADC)) tcr_monitor_inst (.pclk, .presetn, .psel,
   .penable, .pwrite, .ext_timer_clock_in, .alt_timer_clock_in, .aux_clock,
   .sub_main_clock, .timer_pin_out, .timer_pin_oe_n, .adc_trigger_select,
   .powerup_trigger_select, .sequencer_trigger_select, .adc_trigger,
   .ultrasonic_powerup_trigger, .acq_sequencer_trigger);

`default_nettype wire

// ---- sim/tcr_trig_sink.sv ----
/*
 * Model of the trigger inputs of adc, power-up and sequencer blocks:
 * counts rising edges of each trigger.
 * Assumes triggers are synchronous to pclk.
 */
`timescale 1ns/100ps
`default_nettype none

module tcr_trig_sink (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic adc_trigger,
   input wire logic ultrasonic_powerup_trigger,
   input wire logic acq_sequencer_trigger,
   output logic [7:0] adc_hits,
   output logic [7:0] pwr_hits,
   output logic [7:0] seq_hits
);
   logic [2:0] prev;

   // a consumer acts once per rising edge of its trigger
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev <= 3'h0;
         adc_hits <= 8'h00;
         pwr_hits <= 8'h00;
         seq_hits <= 8'h00;
      end else begin
         prev <= {adc_trigger, ultrasonic_powerup_trigger, acq_sequencer_trigger};
         adc_hits <= adc_hits + 8'(adc_trigger & ~prev[2]);
         pwr_hits <= pwr_hits + 8'(ultrasonic_powerup_trigger & ~prev[1]);
         seq_hits <= seq_hits + 8'(acq_sequencer_trigger & ~prev[0]);
      end
   end
endmodule

`default_nettype wire

// ---- verilog/tcr_ccu.sv ----
/*
 * One capture/compare unit: captures the counter on a rising edge of the
 * selected input, or matches the counter and shapes an output level.
 * Assumes the counter struct comes from the owning timer in pclk domain.
 */
`timescale 1ns/100ps
`default_nettype none
`include "tcr_params.svh"

module tcr_ccu (
   input wire logic pclk,
   input wire logic presetn,
   input wire tcr_pkg::tcr_cctl_t cfg,
   input wire tcr_pkg::tcr_cnt_t cnt,
   input wire logic ccr_wr,
   input wire logic [15:0] ccr_wdata,
   input wire logic cap_a,
   input wire logic cap_b,
   output logic [15:0] ccr,
   output logic out_level,
   output logic event_pulse
);

   logic cap_lvl;
   logic cap_prev;
   logic cap_edge;
   logic match;

   // capture input selection
   always_comb begin
      unique case (cfg.cap_sel)
         tcr_pkg::TCR_CAP_A: cap_lvl = cap_a;
         tcr_pkg::TCR_CAP_B: cap_lvl = cap_b;
         tcr_pkg::TCR_CAP_GND: cap_lvl = 1'b0;
         tcr_pkg::TCR_CAP_VCC: cap_lvl = 1'b1;
      endcase
   end

   // previous level for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_prev <= 1'b0;
      end else begin
         cap_prev <= cap_lvl;
      end
   end

   // capture or compare event of this unit
   assign cap_edge = cfg.capture & cap_lvl & ~cap_prev; // RULE3
   assign match = ~cfg.capture & cnt.tick & (cnt.count_next == ccr); // RULE3
   assign event_pulse = cap_edge | match; // RULE5

   // compare value, overwritten by a capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ccr <= `TCR_CCR_RST;
      end else if (cap_edge) begin
         ccr <= cnt.count; // RULE3
      end else if (ccr_wr) begin
         ccr <= ccr_wdata;
      end
   end

   // output shaping: level, pwm, toggle, inverted pwm
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_level <= 1'b0;
      end else begin
         unique case (cfg.out_mode)
            tcr_pkg::TCR_OUT_BIT: begin
               out_level <= cfg.out_bit;
            end
            tcr_pkg::TCR_OUT_PWM: begin
               if (match) begin
                  out_level <= 1'b0; // RULE3
               end else if (cnt.wrap) begin
                  out_level <= 1'b1;
               end
            end
            tcr_pkg::TCR_OUT_TOGGLE: begin
               if (match) begin
                  out_level <= ~out_level; // RULE3
               end
            end
            tcr_pkg::TCR_OUT_PWM_INV: begin
               if (match) begin
                  out_level <= 1'b1;
               end else if (cnt.wrap) begin
                  out_level <= 1'b0;
               end
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// ---- verilog/tcr_params.svh ----
/*
 * Register offsets, field positions, reset values and trigger codes of
 * the timer capture/compare block.
 * Assumes inclusion by bare name from files that need the numbers.
 */
`ifndef TCR_PARAMS_SVH
`define TCR_PARAMS_SVH

// per-timer register window, timer slot in paddr[7:6]
`define TCR_TMR_STRIDE 12'h040
`define TCR_OFF_CTL 6'h00
`define TCR_OFF_CNT 6'h04
`define TCR_OFF_CCTL0 6'h08
`define TCR_OFF_COMPARE_UNIT_0 6'h0c
`define TCR_UNIT_STRIDE 6'h08
// shared interrupt registers
`define TCR_OFF_IFG 12'h100
`define TCR_OFF_IE 12'h104

// control register fields
`define TCR_CTL_CLKSEL_LSB 0
`define TCR_CTL_RUN_BIT 2
`define TCR_CTL_CLR_BIT 3
// unit control register fields
`define TCR_CCTL_CAP_BIT 0
`define TCR_CCTL_CAPSEL_LSB 1
`define TCR_CCTL_OUTMODE_LSB 3
`define TCR_CCTL_OUTBIT_BIT 5
`define TCR_CCTL_PINEN_BIT 6

// reset values
`define TCR_CTL_RST 4'h0
`define TCR_CNT_RST 16'h0000
`define TCR_CCTL_RST 7'h00
`define TCR_CCR_RST 16'h0000
`define TCR_IFG_RST 12'h000
`define TCR_IE_RST 12'h000
`define TCR_CNT_MAX 16'hffff

// trigger select codes of the consuming blocks
`define TCR_ADC_SEL_T0 4'h1
`define TCR_ADC_SEL_T1 4'h4
`define TCR_PWRUP_SEL_T0 2'h2
`define TCR_SEQ_SEL_T1 2'h2

`endif

// ---- verilog/tcr_pkg.sv ----
/*
 * Types of the timer capture/compare block: selections, modes and the
 * structs that carry control and counter state between modules.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package tcr_pkg;

   typedef enum logic [1:0] {
      TCR_CLK_EXT = 2'b00,
      TCR_CLK_AUX = 2'b01,
      TCR_CLK_SUB = 2'b10,
      TCR_CLK_ALT = 2'b11
   } tcr_clksel_t;

   typedef enum logic [1:0] {
      TCR_CAP_A = 2'b00,
      TCR_CAP_B = 2'b01,
      TCR_CAP_GND = 2'b10,
      TCR_CAP_VCC = 2'b11
   } tcr_capsel_t;

   typedef enum logic [1:0] {
      TCR_OUT_BIT = 2'b00,
      TCR_OUT_PWM = 2'b01,
      TCR_OUT_TOGGLE = 2'b10,
      TCR_OUT_PWM_INV = 2'b11
   } tcr_outmode_t;

   // timer control, bit 3 down to bit 0
   typedef struct packed {
      logic clear;
      logic run;
      tcr_clksel_t clk_sel;
   } tcr_ctl_t;

   // unit control, bit 6 down to bit 0
   typedef struct packed {
      logic pin_en;
      logic out_bit;
      tcr_outmode_t out_mode;
      tcr_capsel_t cap_sel;
      logic capture;
   } tcr_cctl_t;

   // counter state shared by all units of one timer
   typedef struct packed {
      logic tick;
      logic wrap;
      logic [15:0] count;
      logic [15:0] count_next;
   } tcr_cnt_t;

endpackage

`default_nettype wire

// ---- verilog/tcr_top.sv ----
/*
 * Three 16-bit capture/compare timers (slots 0, 1 and 2 = timer_4) with
 * their pin and trigger routing, reached over an APB slave.
 * Assumes all inputs are synchronous to pclk; trigger select fields come
 * from the consuming blocks.
 */
// The APB interface to the registers and the register addresses are this design's own decisions.
// Overview of operation
// RULE1: each timer has a free-running 16-bit counter
// RULE2: timers 0,1 three units; timer_4 two
// RULE3: units do capture or compare, pwm, intervals
// RULE4: counter wrap to zero raises a flag
// RULE5: each unit flags capture or compare events
// RULE6: clock from pin, alternate pin, aux, sub-main
// RULE7: unit 1 input b is the comparator (timer_4 unit 1 takes cap_b_pin_in instead)
// RULE8: unit 2 input b is the aux clock
// RULE9: timer 0 unit 1 triggers adc, select 1
// RULE10: timer 1 unit 1 triggers adc, select 4
// RULE11: timer 0 unit 2 powers up, select 2
// RULE12: timer 1 unit 2 starts sequencer, select 2
// RULE13: adc trigger paths exist only with adc
// RULE14: unit output drives its pin when enabled
`timescale 1ns/100ps
`default_nettype none
`include "tcr_params.svh"

module tcr_top #(
   parameter int UNITS_T01 = 3,
   parameter int UNITS_T4 = 2,
   parameter bit HAS_ADC = 1'b1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic [2:0] ext_timer_clock_in,
   input wire logic [2:0] alt_timer_clock_in,
   input wire logic aux_clock,
   input wire logic sub_main_clock,
   input wire logic comparator_output,
   input wire logic [2:0][2:0] cap_a_pin_in,
   input wire logic [2:0][2:0] cap_b_pin_in,
   output logic [2:0][2:0] timer_pin_out,
   output logic [2:0][2:0] timer_pin_oe_n,
   input wire logic [3:0] adc_trigger_select,
   input wire logic [1:0] powerup_trigger_select,
   input wire logic [1:0] sequencer_trigger_select,
   output logic adc_trigger,
   output logic ultrasonic_powerup_trigger,
   output logic acq_sequencer_trigger
);

   tcr_pkg::tcr_ctl_t ctl [3];
   logic [15:0] count [3];
   logic src_prev [3];
   tcr_pkg::tcr_cnt_t cnt_bus [3];
   tcr_pkg::tcr_cctl_t cctl [3][3];
   logic [15:0] ccr_q [3][3];
   logic out_lvl [3][3];
   logic unit_ev [3][3];
   logic [11:0] ifg;
   logic [11:0] ie;
   logic [11:0] events;
   logic [31:0] rd_mux;
   logic hit;
   logic sel_ctl [3];
   logic sel_cnt [3];
   logic sel_cctl [3][3];
   logic sel_ccr [3][3];
   logic sel_ifg;
   logic sel_ie;
   logic err_q;
   logic wr_acc;
   logic [1:0] slot;
   logic [5:0] off;

   // unit presence per timer slot
   function automatic logic unit_present(input logic [1:0] t, input int u);
      unit_present = (t == 2'd2) ? (u < UNITS_T4) : (u < UNITS_T01); // RULE2
   endfunction

   assign slot = paddr[7:6];
   assign off = paddr[5:0];
   assign wr_acc = psel & penable & pwrite;

   // address decode and read data selection
   always_comb begin
      hit = 1'b0;
      rd_mux = 32'h0000_0000;
      sel_ifg = 1'b0;
      sel_ie = 1'b0;
      for (int t = 0; t < 3; t++) begin
         sel_ctl[t] = 1'b0;
         sel_cnt[t] = 1'b0;
         for (int u = 0; u < 3; u++) begin
            sel_cctl[t][u] = 1'b0;
            sel_ccr[t][u] = 1'b0;
         end
      end
      if (paddr == `TCR_OFF_IFG) begin
         hit = 1'b1;
         sel_ifg = 1'b1;
         rd_mux = {20'h00000, ifg};
      end else if (paddr == `TCR_OFF_IE) begin
         hit = 1'b1;
         sel_ie = 1'b1;
         rd_mux = {20'h00000, ie};
      end else if (paddr[11:8] == 4'h0 && slot != 2'b11) begin
         for (int t = 0; t < 3; t++) begin
            if (slot == 2'(t)) begin
               if (off == `TCR_OFF_CTL) begin
                  hit = 1'b1;
                  sel_ctl[t] = 1'b1;
                  rd_mux = {28'h0000000, ctl[t]};
               end else if (off == `TCR_OFF_CNT) begin
                  hit = 1'b1;
                  sel_cnt[t] = 1'b1;
                  rd_mux = {16'h0000, count[t]};
               end
               for (int u = 0; u < 3; u++) begin
                  if (unit_present(slot, u)) begin
                     if (off == `TCR_OFF_CCTL0 + 6'(u) * `TCR_UNIT_STRIDE) begin
                        hit = 1'b1;
                        sel_cctl[t][u] = 1'b1;
                        rd_mux = {25'h0000000, cctl[t][u]};
                     end else if (off == `TCR_OFF_COMPARE_UNIT_0 + 6'(u) * `TCR_UNIT_STRIDE) begin
                        hit = 1'b1;
                        sel_ccr[t][u] = 1'b1;
                        rd_mux = {16'h0000, ccr_q[t][u]};
                     end
                  end
               end
            end
         end
      end
   end

   // read data and error latched in the setup cycle, answered in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         err_q <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_mux;
         err_q <= ~hit;
      end
   end

   assign pready = 1'b1;
   assign pslverr = psel & penable & err_q;

   // timers: clock select, counter, units
   for (genvar t = 0; t < 3; t++) begin : g_tmr
      logic src_lvl;
      logic tick;

      // counter clock source selection
      always_comb begin
         unique case (ctl[t].clk_sel)
            tcr_pkg::TCR_CLK_EXT: src_lvl = ext_timer_clock_in[t]; // RULE6
            tcr_pkg::TCR_CLK_AUX: src_lvl = aux_clock; // RULE6
            tcr_pkg::TCR_CLK_SUB: src_lvl = sub_main_clock; // RULE6
            tcr_pkg::TCR_CLK_ALT: src_lvl = alt_timer_clock_in[t]; // RULE6
         endcase
      end

      // source level of the previous cycle
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            src_prev[t] <= 1'b0;
         end else begin
            src_prev[t] <= src_lvl;
         end
      end

      assign tick = ctl[t].run & src_lvl & ~src_prev[t];
      assign cnt_bus[t].tick = tick;
      assign cnt_bus[t].count = count[t];
      assign cnt_bus[t].count_next = count[t] + 16'h0001; // RULE1
      assign cnt_bus[t].wrap = tick & (count[t] == `TCR_CNT_MAX); // RULE4

      // timer control; the clear bit is a self-clearing command
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            ctl[t] <= `TCR_CTL_RST;
         end else if (wr_acc && sel_ctl[t]) begin
            ctl[t].clk_sel <= tcr_pkg::tcr_clksel_t'(pwdata[`TCR_CTL_CLKSEL_LSB +: 2]);
            ctl[t].run <= pwdata[`TCR_CTL_RUN_BIT];
            ctl[t].clear <= 1'b0;
         end
      end

      // free-running counter, wraps from all ones to zero
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            count[t] <= `TCR_CNT_RST;
         end else if (wr_acc && sel_ctl[t] && pwdata[`TCR_CTL_CLR_BIT]) begin
            count[t] <= `TCR_CNT_RST;
         end else if (wr_acc && sel_cnt[t]) begin
            count[t] <= pwdata[15:0];
         end else if (tick) begin
            count[t] <= cnt_bus[t].count_next; // RULE1
         end
      end

      assign events[4 * t] = cnt_bus[t].wrap; // RULE4

      for (genvar u = 0; u < 3; u++) begin : g_unit
         if ((t == 2) ? (u < UNITS_T4) : (u < UNITS_T01)) begin : g_on
            logic cap_b;

            // internal capture b sources of timers 0 and 1
            if (t < 2 && u == 1) begin : g_cmp
               assign cap_b = comparator_output; // RULE7
            end else if (t < 2 && u == 2) begin : g_aux
               assign cap_b = aux_clock; // RULE8
            end else begin : g_pin
               assign cap_b = cap_b_pin_in[t][u];
            end

            // unit control register
            always_ff @(posedge pclk or negedge presetn) begin
               if (!presetn) begin
                  cctl[t][u] <= `TCR_CCTL_RST;
               end else if (wr_acc && sel_cctl[t][u]) begin
                  cctl[t][u] <= pwdata[6:0];
               end
            end

            tcr_ccu u_ccu (
               .pclk(pclk),
               .presetn(presetn),
               .cfg(cctl[t][u]),
               .cnt(cnt_bus[t]),
               .ccr_wr(wr_acc & sel_ccr[t][u]),
               .ccr_wdata(pwdata[15:0]),
               .cap_a(cap_a_pin_in[t][u]), // RULE7
               .cap_b(cap_b),
               .ccr(ccr_q[t][u]),
               .out_level(out_lvl[t][u]),
               .event_pulse(unit_ev[t][u])
            ); // RULE2

            // pin driven by the unit output when enabled
            assign timer_pin_out[t][u] = out_lvl[t][u]; // RULE14
            assign timer_pin_oe_n[t][u] = ~cctl[t][u].pin_en; // RULE14
         end else begin : g_off
            assign cctl[t][u] = `TCR_CCTL_RST;
            assign ccr_q[t][u] = `TCR_CCR_RST;
            assign out_lvl[t][u] = 1'b0;
            assign unit_ev[t][u] = 1'b0;
            assign timer_pin_out[t][u] = 1'b0;
            assign timer_pin_oe_n[t][u] = 1'b1;
         end
         assign events[4 * t + 1 + u] = unit_ev[t][u]; // RULE5
      end
   end

   // sticky flags; a new event wins over a write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ifg <= `TCR_IFG_RST;
      end else if (wr_acc && sel_ifg) begin
         ifg <= (ifg & ~pwdata[11:0]) | events; // RULE4 RULE5
      end else begin
         ifg <= ifg | events; // RULE4 RULE5
      end
   end

   // interrupt mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ie <= `TCR_IE_RST;
      end else if (wr_acc && sel_ie) begin
         ie <= pwdata[11:0];
      end
   end

   assign irq = |(ifg & ie);

   // hardware triggers to the adc, power-up and sequencer blocks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_trigger <= 1'b0;
         ultrasonic_powerup_trigger <= 1'b0;
         acq_sequencer_trigger <= 1'b0;
      end else begin
         adc_trigger <= HAS_ADC & // RULE13
            (((adc_trigger_select == `TCR_ADC_SEL_T0) & out_lvl[0][1]) | // RULE9
             ((adc_trigger_select == `TCR_ADC_SEL_T1) & out_lvl[1][1])); // RULE10
         ultrasonic_powerup_trigger <=
            (powerup_trigger_select == `TCR_PWRUP_SEL_T0) & out_lvl[0][2]; // RULE11
         acq_sequencer_trigger <=
            (sequencer_trigger_select == `TCR_SEQ_SEL_T1) & out_lvl[1][2]; // RULE12
      end
   end

endmodule

`default_nettype wire
